//--- rtl/fpl_pkg.sv
package fpl_pkg;

  // Register byte addresses on the Avalon-MM slave.
  localparam logic [12:0] FPL_OFS_CFG      = 13'h13B4;
  localparam logic [12:0] FPL_OFS_STATUS   = 13'h13D0;
  localparam logic [12:0] FPL_OFS_EXEC     = 13'h1300;
  localparam logic [12:0] FPL_OFS_IRQ_STAT = 13'h1320;
  localparam logic [12:0] FPL_OFS_IRQ_CLR  = 13'h1324;
  localparam logic [12:0] FPL_OFS_IRQ_EN   = 13'h1328;

  // Reset values.
  localparam logic [31:0] FPL_CFG_RST    = 32'h0000_0000;
  localparam logic [31:0] FPL_STATUS_RST = 32'h0000_0000;

  // Field positions of the pulse limit configuration.
  localparam int FPL_PGM_OVR_BIT = 0;
  localparam int FPL_PGM_VAL_LO  = 4;
  localparam int FPL_ERS_OVR_BIT = 16;
  localparam int FPL_ERS_VAL_LO  = 20;

  // Field positions of the command status word.
  localparam int FPL_ST_DONE    = 0;
  localparam int FPL_ST_PASS    = 1;
  localparam int FPL_ST_RUN     = 2;
  localparam int FPL_ST_PROT    = 4;
  localparam int FPL_ST_VERIFY  = 5;
  localparam int FPL_ST_ILLADDR = 6;
  localparam int FPL_ST_MODE    = 7;
  localparam int FPL_ST_MISC    = 12;

  // Hard-wired maximum pulse count when no override is active.
  localparam logic [11:0] FPL_HW_MAX_PULSES = 12'h3E8;

  // Command execute trigger field: bit 0 starts, bit 1 selects erase.
  localparam int FPL_EXEC_GO  = 0;
  localparam int FPL_EXEC_ERS = 1;

  // Interrupt event bit positions.
  localparam int FPL_IRQ_DONE = 0;
  localparam int FPL_IRQ_FAIL = 1;

  // Sequencer states, Gray coded along idle-check-pulse-wait-finish.
  typedef enum logic [2:0] {
    FPL_IDLE  = 3'b000,
    FPL_CHECK = 3'b001,
    FPL_PULSE = 3'b011,
    FPL_WAIT  = 3'b010,
    FPL_FIN   = 3'b110
  } fpl_state_e;

  // Avalon-MM request bundle.
  typedef struct packed {
    logic [12:0] address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } fpl_avm_req_s;

  // Flash array side answers for one pulse.
  typedef struct packed {
    logic pulse_ack;
    logic verify_ok;
    logic prot_hit;
    logic addr_bad;
    logic misc_err;
  } fpl_array_rsp_s;

endpackage

//--- rtl/fpl_byte_reg.sv
`timescale 1ns/1ns
// One 32-bit register with per-byte write enables, lock gating and registered read-out.
module fpl_byte_reg (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic [3:0]  be_in,
  input  wire logic        lock_in,
  input  wire logic [31:0] wdata_in,
  output logic      [31:0] q_out
);
  import fpl_pkg::*;

  // Each byte lane updates on its own enable unless the lock holds.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          q_out[g*8 +: 8] <= FPL_CFG_RST[g*8 +: 8];
        end else if (be_in[g] && !lock_in) begin
          q_out[g*8 +: 8] <= wdata_in[g*8 +: 8];
        end
      end
    end
  endgenerate
endmodule

//--- rtl/fpl_top.sv
`timescale 1ns/1ns
module fpl_top (
  input  wire logic                     ref_clk_in,
  input  wire logic                     nrst_in,
  input  wire fpl_pkg::fpl_avm_req_s    avm_req_in,
  output logic                          avm_waitrequest_out,
  output logic                          avm_readdatavalid_out,
  output logic [31:0]                   avm_readdata_out,
  input  wire logic                     banks_read_mode_in,
  input  wire fpl_pkg::fpl_array_rsp_s  array_rsp_in,
  output logic                          pulse_req_out,
  output logic                          pulse_erase_out,
  output logic [11:0]                   pulse_count_out,
  output logic                          irq_out
);
  import fpl_pkg::*;

  fpl_state_e  state_r;
  logic [31:0] cfg_q;
  logic [31:0] status_r;
  logic        erase_r;
  logic [11:0] count_r;
  logic [11:0] limit_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_en_r;
  logic        ack_r;
  logic        busy;
  logic        wr_acc;
  logic        rd_acc;
  logic        exec_go;
  logic [3:0]  cfg_be;
  logic [11:0] pgm_lim;
  logic [11:0] ers_lim;
  logic        ev_done;
  logic        ev_fail;
  logic [1:0]  irq_clr;

  // Every access completes one cycle after it appears; waitrequest is low in that cycle.
  assign wr_acc  = avm_req_in.write && ack_r;
  assign rd_acc  = avm_req_in.read && ack_r;
  assign busy    = (state_r != FPL_IDLE);
  assign exec_go = wr_acc && avm_req_in.address == FPL_OFS_EXEC
                   && avm_req_in.byteenable[0] && avm_req_in.writedata[FPL_EXEC_GO];
  assign cfg_be  = (wr_acc && avm_req_in.address == FPL_OFS_CFG) ? avm_req_in.byteenable : 4'h0;

  // Configuration storage; the lock covers the whole command window.
  fpl_byte_reg u_cfg (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .be_in      (cfg_be),
    .lock_in    (busy),
    .wdata_in   (avm_req_in.writedata),
    .q_out      (cfg_q)
  );

  // Limit selection from the two override bits.
  always_comb begin
    pgm_lim = cfg_q[FPL_PGM_OVR_BIT] ? {4'h0, cfg_q[FPL_PGM_VAL_LO +: 8]}
                                     : FPL_HW_MAX_PULSES;
    if (cfg_q[FPL_ERS_OVR_BIT]) begin
      ers_lim = cfg_q[FPL_ERS_VAL_LO +: 12];
    end else begin
      ers_lim = pgm_lim;
    end
  end

  // Bus handshake: waitrequest drops for exactly one cycle per request.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avm_req_in.read || avm_req_in.write) && !ack_r;
    end
  end

  // Waitrequest is its own register, loaded with the inverse of the handshake register's next value.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avm_waitrequest_out <= 1'b1;
    end else begin
      avm_waitrequest_out <= !((avm_req_in.read || avm_req_in.write) && !ack_r);
    end
  end

  // Read data mux; unmapped addresses read as zero.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avm_readdata_out      <= 32'h0000_0000;
      avm_readdatavalid_out <= 1'b0;
    end else begin
      avm_readdatavalid_out <= avm_req_in.read && !ack_r;
      if (avm_req_in.read && !ack_r) begin
        case (avm_req_in.address)
          FPL_OFS_CFG:      avm_readdata_out <= cfg_q;
          FPL_OFS_STATUS:   avm_readdata_out <= status_r;
          FPL_OFS_IRQ_STAT: avm_readdata_out <= {30'h0000_0000, irq_stat_r};
          FPL_OFS_IRQ_EN:   avm_readdata_out <= {30'h0000_0000, irq_en_r};
          default:          avm_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Command sequencer: check banks, pulse up to the limit, finish.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= FPL_IDLE;
      erase_r <= 1'b0;
      limit_r <= 12'h000;
    end else begin
      case (state_r)
        FPL_IDLE: begin
          if (exec_go) begin
            state_r <= FPL_CHECK;
            erase_r <= avm_req_in.writedata[FPL_EXEC_ERS];
          end
        end
        FPL_CHECK: begin
          limit_r <= erase_r ? ers_lim : pgm_lim;
          state_r <= banks_read_mode_in ? FPL_PULSE : FPL_FIN;
        end
        FPL_PULSE: state_r <= FPL_WAIT;
        FPL_WAIT: begin
          if (array_rsp_in.pulse_ack) begin
            if (array_rsp_in.prot_hit || array_rsp_in.addr_bad || array_rsp_in.misc_err
                || array_rsp_in.verify_ok || count_r >= limit_r) begin
              state_r <= FPL_FIN;
            end else begin
              state_r <= FPL_PULSE;
            end
          end
        end
        FPL_FIN: state_r <= FPL_IDLE;
        default: state_r <= FPL_IDLE;
      endcase
    end
  end

  // Pulse counter, pulse request and erase select outputs.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_r         <= 12'h000;
      pulse_req_out   <= 1'b0;
      pulse_erase_out <= 1'b0;
      pulse_count_out <= 12'h000;
    end else begin
      pulse_req_out <= 1'b0;
      if (state_r == FPL_CHECK) begin
        count_r         <= 12'h000;
        pulse_erase_out <= erase_r;  // The operation select shows even for a refused command.
      end else if (state_r == FPL_PULSE) begin
        count_r         <= count_r + 12'h001;
        pulse_req_out   <= 1'b1;
        pulse_erase_out <= erase_r;
      end
      pulse_count_out <= count_r;
    end
  end

  // Status word: cleared at start, running while busy, results at each pulse answer, done at finish.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_r <= FPL_STATUS_RST;
    end else if (state_r == FPL_IDLE && exec_go) begin
      status_r              <= FPL_STATUS_RST;
      status_r[FPL_ST_RUN]  <= 1'b1;
    end else if (state_r == FPL_CHECK && !banks_read_mode_in) begin
      status_r[FPL_ST_MODE] <= 1'b1;
    end else if (state_r == FPL_WAIT && array_rsp_in.pulse_ack) begin
      status_r[FPL_ST_PROT]    <= array_rsp_in.prot_hit;
      status_r[FPL_ST_ILLADDR] <= array_rsp_in.addr_bad;
      status_r[FPL_ST_MISC]    <= array_rsp_in.misc_err;
      status_r[FPL_ST_VERIFY]  <= !array_rsp_in.verify_ok && count_r >= limit_r
                                  && !array_rsp_in.prot_hit && !array_rsp_in.addr_bad
                                  && !array_rsp_in.misc_err;
      status_r[FPL_ST_PASS]    <= array_rsp_in.verify_ok && !array_rsp_in.prot_hit
                                  && !array_rsp_in.addr_bad && !array_rsp_in.misc_err;
    end else if (state_r == FPL_FIN) begin
      status_r[FPL_ST_DONE] <= 1'b1;
      status_r[FPL_ST_RUN]  <= 1'b0;
    end
  end

  // Interrupt events, clear strobe and sticky status; set wins over clear.
  assign ev_done = (state_r == FPL_FIN);
  assign ev_fail = (state_r == FPL_FIN) && !status_r[FPL_ST_PASS];
  assign irq_clr = (wr_acc && avm_req_in.address == FPL_OFS_IRQ_CLR)
                   ? avm_req_in.writedata[1:0] : 2'b00;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_stat_r <= 2'b00;
      irq_en_r   <= 2'b00;
      irq_out    <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | {ev_fail, ev_done};
      if (wr_acc && avm_req_in.address == FPL_OFS_IRQ_EN) begin
        irq_en_r <= avm_req_in.writedata[1:0];
      end
      irq_out <= |((irq_stat_r & ~irq_clr | {ev_fail, ev_done}) & irq_en_r);
    end
  end

  // Configuration is frozen for the whole command.
  cfg_lock_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    busy && $past(busy) |-> $stable(cfg_q)) else $error("config changed while busy");

  // Erase limit follows the hard-wired value without either override.
  ers_hw_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !cfg_q[16] && !cfg_q[0] |-> ers_lim == FPL_HW_MAX_PULSES)
    else $error("erase limit not hard-wired");

  // Erase limit taken from the 12-bit field with override.
  ers_ovr_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    cfg_q[16] |-> ers_lim == cfg_q[31:20]) else $error("erase override lost");

  // Program override alone covers both operations.
  pgm_both_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    cfg_q[0] && !cfg_q[16] |-> ers_lim == {4'h0, cfg_q[11:4]} && pgm_lim == ers_lim)
    else $error("program override not shared");

  // Both overrides split the limits.
  both_ovr_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    cfg_q[0] && cfg_q[16] |-> pgm_lim == {4'h0, cfg_q[11:4]})
    else $error("program limit wrong");

  // Program uses hard-wired value without its override.
  pgm_hw_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !cfg_q[0] |-> pgm_lim == FPL_HW_MAX_PULSES) else $error("program limit not hard-wired");

  // Done follows the finish state by one cycle with running cleared.
  done_set_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    state_r == FPL_FIN |=> status_r[0] && !status_r[2]) else $error("done not reported");

  // Bank mode refusal issues no pulse and reports the mode failure.
  sequence s_refused;
    state_r == FPL_CHECK && !banks_read_mode_in;
  endsequence
  mode_fail_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_refused |=> status_r[7] && !pulse_req_out ##1 status_r[0] && !status_r[1])
    else $error("bank mode refusal wrong");

  // Pulse count never exceeds the latched limit plus the final pulse.
  pulse_cap_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    state_r == FPL_PULSE |-> count_r <= limit_r) else $error("pulse limit exceeded");

  // Waitrequest stays low for a single cycle per access.
  sequence s_bus_answer;
    !avm_waitrequest_out;
  endsequence
  wait_once_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_bus_answer |=> avm_waitrequest_out)
    else $error("waitrequest held low");

  // Read data valid marks exactly the answer cycle of a read.
  rd_valid_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    rd_acc |-> avm_readdatavalid_out && !avm_waitrequest_out)
    else $error("read answer not flagged");

  // A status read returns the word as it stood when the request was taken.
  status_rd_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    rd_acc && avm_req_in.address == FPL_OFS_STATUS |-> avm_readdata_out == $past(status_r))
    else $error("status read mismatch");

  // Bus writes never reach the read-only status word while idle.
  status_ro_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    state_r == FPL_IDLE && $past(state_r) == FPL_IDLE |-> $stable(status_r))
    else $error("status changed while idle");

  // Running is reported for the whole command, from check to finish.
  run_flag_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    busy |-> status_r[FPL_ST_RUN])
    else $error("running flag missing");

  // Starting a command clears the previous result, so a stale pass never shows.
  sequence s_start;
    state_r == FPL_IDLE && exec_go;
  endsequence
  start_clr_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_start |=> status_r == (32'h1 << FPL_ST_RUN) && state_r == FPL_CHECK)
    else $error("start did not clear status");

  // Running out of pulses ends in a verify failure, then done without pass.
  sequence s_exhausted;
    state_r == FPL_WAIT && array_rsp_in.pulse_ack && !array_rsp_in.verify_ok
    && !array_rsp_in.prot_hit && !array_rsp_in.addr_bad && !array_rsp_in.misc_err
    && count_r >= limit_r;
  endsequence
  sequence s_verify_end;
    state_r == FPL_FIN && status_r[FPL_ST_VERIFY] ##1 status_r[FPL_ST_DONE]
    && !status_r[FPL_ST_PASS] && !busy;
  endsequence
  verify_end_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_exhausted |=> s_verify_end)
    else $error("pulse limit end wrong");

  // A pulse request lasts one cycle; the next one waits for the array answer.
  pulse_once_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    pulse_req_out |=> !pulse_req_out)
    else $error("pulse request too long");

  // No pulse leaves the block while the sequencer is idle or checking the banks.
  pulse_idle_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    state_r == FPL_IDLE || state_r == FPL_CHECK |-> !pulse_req_out)
    else $error("pulse outside a command");

  // The latched erase limit follows the 12-bit field under erase override.
  ers_latch_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    state_r == FPL_CHECK && erase_r && cfg_q[FPL_ERS_OVR_BIT]
    |=> limit_r == cfg_q[FPL_ERS_VAL_LO +: 12])
    else $error("erase limit not latched");

  // The latched program limit is the zero-extended 8-bit field under program override.
  pgm_latch_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    state_r == FPL_CHECK && !erase_r && cfg_q[FPL_PGM_OVR_BIT]
    |=> limit_r == {4'h0, cfg_q[FPL_PGM_VAL_LO +: 8]})
    else $error("program limit not latched");

  // A full-word configuration write while idle lands as written, reserved bits included.
  cfg_wr_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    wr_acc && !busy && avm_req_in.address == FPL_OFS_CFG && avm_req_in.byteenable == 4'hF
    |=> cfg_q == $past(avm_req_in.writedata))
    else $error("config write lost");

  // The interrupt line reflects enabled sticky bits once the enables are settled.
  irq_level_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $stable(irq_en_r) |-> irq_out == |(irq_stat_r & irq_en_r))
    else $error("interrupt level wrong");

  // A second execute during a command does not restart the sequencer.
  exec_busy_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    busy && exec_go |=> state_r != FPL_CHECK)
    else $error("execute taken while busy");

endmodule

//--- testbench/fpl_array_model.sv
`timescale 1ns/1ns
// Behavioural flash array: answers each pulse after a few cycles of delay.
module fpl_array_model (
  input  wire logic                    ref_clk_in,
  input  wire logic                    nrst_in,
  input  wire logic                    pulse_req_in,
  input  wire logic [11:0]             pulse_count_in,
  input  wire logic [11:0]             ok_at_in,
  input  wire logic [1:0]              dly_in,
  input  wire logic [2:0]              err_in,
  output fpl_pkg::fpl_array_rsp_s      rsp_out
);
  import fpl_pkg::*;
  logic       busy_r;
  logic [1:0] cnt_r;
  logic       tog_r;

  // Acknowledge only after a request; the flags toggle when not qualified by the ack.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_r  <= 1'b0;
      cnt_r   <= 2'h0;
      tog_r   <= 1'b0;
      rsp_out <= '0;
    end else begin
      tog_r   <= ~tog_r;
      rsp_out <= {1'b0, {4{tog_r}}};
      if (pulse_req_in) begin
        busy_r <= 1'b1;
        cnt_r  <= dly_in;
      end else if (busy_r && cnt_r != 2'h0) begin
        cnt_r <= cnt_r - 2'h1;
      end else if (busy_r) begin
        busy_r  <= 1'b0;
        rsp_out <= {1'b1, pulse_count_in == ok_at_in, err_in};
      end
    end
  end
endmodule

//--- testbench/fpl_top_tb.sv
`timescale 1ns/1ns
module fpl_top_tb;
  import fpl_pkg::*;
  logic           ref_clk_in;
  logic           nrst_in;
  logic           banks_ok;
  logic           preq;
  logic           pers;
  logic           wreq;
  logic           irq;
  logic           rdv;
  logic           rdv_seen;
  logic [31:0]    rd_o;
  logic [31:0]    rdata;
  logic [31:0]    cfg;
  logic [31:0]    d;
  logic [11:0]    pcnt;
  logic [11:0]    ok_at;
  logic [1:0]     dly;
  logic [2:0]     err;
  fpl_avm_req_s   req;
  fpl_array_rsp_s rsp;
  int             fails;
  int             compares;
  int             npulse;
  int             i;
  int             b;

  fpl_top fpl_top_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .avm_req_in(req),
    .avm_waitrequest_out(wreq), .avm_readdatavalid_out(rdv), .avm_readdata_out(rd_o),
    .banks_read_mode_in(banks_ok), .array_rsp_in(rsp), .pulse_req_out(preq),
    .pulse_erase_out(pers), .pulse_count_out(pcnt), .irq_out(irq));
  fpl_array_model fpl_array_model_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .pulse_req_in(preq), .pulse_count_in(pcnt), .ok_at_in(ok_at), .dly_in(dly),
    .err_in(err), .rsp_out(rsp));

  // Free-running 100 MHz clock.
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // Counts the pulses fired during a command.
  always @(posedge ref_clk_in) if (preq === 1'b1) npulse++;

  task automatic stop_test;
    if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low.
  task automatic acc(input logic r, input logic [12:0] a, input logic [31:0] w,
                     input logic [3:0] be);
    int n;
    @(posedge ref_clk_in);
    req <= '{a, r, !r, be, w};
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      fails++;
      stop_test;
    end
    rdata = rd_o;
    rdv_seen = rdv;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wr(input logic [12:0] a, input logic [31:0] w);
    acc(1'b0, a, w, 4'hF);
  endtask

  task automatic rd(input logic [12:0] a);
    acc(1'b1, a, 32'h0, 4'hF);
    chk({31'h0, rdv_seen}, 32'h1);
  endtask

  // Expected pulse limit for a configuration and operation.
  function automatic logic [31:0] lim(input logic [31:0] c, input logic e);
    if (e && c[FPL_ERS_OVR_BIT]) return {20'h0, c[31:20]};
    if (c[FPL_PGM_OVR_BIT]) return {24'h0, c[11:4]};
    return {20'h0, FPL_HW_MAX_PULSES};
  endfunction

  // Starts a command, tries to overwrite the locked configuration, then checks the result.
  task automatic run(input logic e, input logic [31:0] m, input logic [31:0] x, input int np);
    int n;
    rd(FPL_OFS_CFG);
    d = rdata;
    npulse = 0;
    wr(FPL_OFS_EXEC, {30'h0, e, 1'b1});
    wr(FPL_OFS_CFG, ~d);
    if (np > 1) begin
      rd(FPL_OFS_STATUS);
      chk(rdata & 32'h7, 32'h4);
    end
    // A second execute with the other operation must be ignored while busy.
    if (np > 3) wr(FPL_OFS_EXEC, {30'h0, ~e, 1'b1});
    n = 0;
    do begin
      rd(FPL_OFS_STATUS);
      n++;
    end while (rdata[FPL_ST_DONE] !== 1'b1 && n < 9000);
    if (n >= 9000) begin
      fails++;
      stop_test;
    end
    chk(rdata & m, x);
    if (np >= 0) chk(32'(npulse), 32'(np));
    if (np >= 0) chk({20'h0, pcnt}, 32'(np));
    chk({31'h0, pers}, {31'h0, e});
    rd(FPL_OFS_CFG);
    // A refused command is done before the write arrives, so that write is taken.
    chk(rdata, (np == 0) ? ~d : d);
  endtask

  // Main sequence.
  initial begin
    nrst_in = 1'b0;
    req = '0;
    banks_ok = 1'b1;
    ok_at = 12'h0;
    dly = 2'h0;
    err = 3'h0;
    fails = 0;
    compares = 0;
    npulse = 0;
    i = $urandom(32'hADD2);
    repeat (10) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    rd(FPL_OFS_CFG);
    chk(rdata, FPL_CFG_RST);
    rd(FPL_OFS_STATUS);
    chk(rdata, FPL_STATUS_RST);
    wr(FPL_OFS_STATUS, 32'hFFFFFFFF);
    rd(FPL_OFS_STATUS);
    chk(rdata, 32'h0);
    acc(1'b0, FPL_OFS_CFG, 32'hFFFFFFFF, 4'h1);
    rd(FPL_OFS_CFG);
    chk(rdata, 32'h000000FF);
    wr(FPL_OFS_CFG, 32'hFFFFFFFF);
    rd(FPL_OFS_CFG);
    chk(rdata, 32'hFFFFFFFF);
    rd(13'h0004);
    chk(rdata, 32'h0);
    wr(FPL_OFS_IRQ_EN, 32'h3);
    // Every override combination for program and erase, running out of pulses.
    for (i = 0; i < 9; i++) begin
      cfg = {12'(1 + $urandom % 40), 3'h0, i[1], 4'h0, 8'(1 + $urandom % 40), 3'h0, i[0]};
      if (i == 8) cfg = 32'h00000FF1;
      dly <= 2'($urandom);
      wr(FPL_OFS_CFG, cfg);
      run(i[2], 32'hFFFFFFFF, 32'h21, lim(cfg, i[2]));
      chk({31'h0, irq}, 32'h1);
      rd(FPL_OFS_IRQ_STAT);
      chk(rdata & 32'h3, 32'h3);
      wr(FPL_OFS_IRQ_CLR, 32'h3);
      rd(FPL_OFS_IRQ_STAT);
      chk(rdata, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    // Success on the third pulse, with the interrupt masked.
    wr(FPL_OFS_IRQ_EN, 32'h0);
    ok_at <= 12'h3;
    wr(FPL_OFS_CFG, 32'h00000141);
    run(1'b0, 32'hFFFFFFFF, 32'h3, 3);
    chk({31'h0, irq}, 32'h0);
    rd(FPL_OFS_IRQ_STAT);
    chk(rdata & 32'h1, 32'h1);
    wr(FPL_OFS_IRQ_CLR, 32'h3);
    // A bank out of read mode refuses the command.
    ok_at <= 12'h0;
    banks_ok <= 1'b0;
    run(1'b1, 32'hFFFFFFFF, 32'h81, 0);
    banks_ok <= 1'b1;
    // Each array error reaches its own status bit.
    for (i = 0; i < 3; i++) begin
      b = (i == 0) ? FPL_ST_PROT : (i == 1) ? FPL_ST_ILLADDR : FPL_ST_MISC;
      err <= 3'h4 >> i;
      run(1'b0, (32'h1 << b) | 32'h3, (32'h1 << b) | 32'h1, -1);
    end
    err <= 3'h0;
    stop_test;
  end
endmodule
